// ==== io_instruction_unit_consts.svh ====
// Constants for the I/O instruction unit: opcodes, field positions, register offsets.
// Contract
// - Condition test skips one when state differs.
// - Equal markers mean empty table; continue.
// - Entry loads character, identity, direction registers.
// - Unload marker wraps forward; next instruction skipped.
// - High table instruction: one or two cycles.
// - Low table instruction: one or two cycles.
// - Enable starts one of eight scanner positions.
// - Disable stops position now, drops partial character.
// - Initiate on busy channel just advances.
// - Idle channel gets command then block word.
// - Successful initiate resumes at address plus two.
// - Transfer end sets flag; unmasked flag interrupts.
// - One transfer per channel at a time.
// - Initiate decodes opcode, channel, indirect, index, address.
// - Command address modified; index one means nothing.
// - Command word: device select, operation code.
// - Block word: 12-bit length, 18-bit start.
// - Save copies two channel words, three cycles.
// - Save and halt need no prior initiate.
// - Halt ends channel transfer immediately.
// - Sixteen channels, each with own registers.
// - Channel memory access shares with instruction unit.
// - Halt leaves channel registers undefined.
`ifndef IO_INSTRUCTION_UNIT_CONSTS_SVH
`define IO_INSTRUCTION_UNIT_CONSTS_SVH
`define OP_TEST_COND 6'h2c
`define OP_HIGH_CYCLE 6'h30
`define OP_LOW_CYCLE 6'h31
`define OP_SCAN_ENABLE 6'h32
`define OP_SCAN_DISABLE 6'h33
`define OP_IO_INITIATE 6'h34
`define OP_IO_SAVE 6'h35
`define OP_IO_HALT 6'h36
`define F_OP_HI 31
`define F_OP_LO 26
`define F_UBIT 25
`define F_CHAN_HI 25
`define F_CHAN_LO 22
`define F_POS_HI 24
`define F_POS_LO 22
`define F_IND 21
`define F_X_HI 20
`define F_X_LO 18
`define F_W_HI 17
`define F_W_LO 2
`define X_NONE 3'h0
`define X_NO_MEANING 3'h1
`define PC_STEP 18'h00001
`define PC_SKIP 18'h00002
`define REG_MASK 8'h00
`define REG_DONE 8'h04
`define REG_BUSY 8'h08
`define REG_SCAN 8'h0c
`define REG_MARKERS 8'h10
`endif

// ==== io_instruction_unit_pkg.sv ====
// Types shared by the I/O instruction unit and its surroundings.
package io_instruction_unit_pkg;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_CAT_LOAD = 9'h002,
    S_IND_READ = 9'h004,
    S_IND_TAKE = 9'h008,
    S_CMD_READ = 9'h010,
    S_BCW_READ = 9'h020,
    S_BCW_TAKE = 9'h040,
    S_SAVE_CMD = 9'h080,
    S_SAVE_BCW = 9'h100
  } state_e;
  typedef struct packed {
    logic [7:0] character;
    logic [5:0] ident;
    logic io_dir;
  } cat_entry_s;
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] device_select_field;
    logic [9:0] dev_op;
    logic [15:0] unused;
  } cmd_word_s;
  typedef struct packed {
    logic [1:0] spare;
    logic [11:0] block_len;
    logic [17:0] start_addr;
  } bcw_s;
endpackage

// ==== io_instruction_unit.sv ====
// Execution logic for condition-test, line-scanner and I/O-channel instructions.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "io_instruction_unit_consts.svh"
module io_instruction_unit
  import io_instruction_unit_pkg::*;
#(
  parameter int CAT_DEPTH = 16, // entries in each activity table
  parameter int MARK_W = 4, // width of load and unload markers
  parameter int NUM_CH = 16, // I/O channels
  parameter int NUM_POS = 8 // scanner positions
)(
  input wire logic clock, // 20 MHz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic instr_valid, // one-cycle issue of an instruction
  input wire logic [31:0] instr_word, // instruction word
  input wire logic [17:0] instr_pc, // address of the issued instruction
  output logic instr_ready, // unit can take an instruction
  output logic done, // instruction finished, one-cycle pulse
  output logic [17:0] next_pc, // address of next instruction to run
  output logic [2:0] xr_sel, // index register selected by X
  input wire logic [15:0] xr_val, // value of selected index register
  output logic [15:0] cond_sel, // memo or switch addressed by W
  input wire logic cond_val, // state of addressed memo or switch
  output logic [7:0] reg_e, // character register
  output logic [5:0] reg_f, // channel identity register
  output logic reg_g, // input/output indicator register
  input wire logic cat_wr_valid, // scanner offers a table entry
  input wire logic cat_wr_high, // entry goes to the high table
  input wire cat_entry_s cat_wr_entry, // entry contents
  output logic cat_wr_ready, // target table has room
  output logic [NUM_POS-1:0] scan_en, // scanner positions in operation
  output logic scan_drop, // partial character at scan_drop_pos is lost
  output logic [2:0] scan_drop_pos, // position being disabled
  output logic ch_start, // start a channel, one-cycle pulse
  output logic ch_halt, // stop a channel at once, one-cycle pulse
  output logic [3:0] ch_sel, // channel for start or halt
  output cmd_word_s ch_cmd, // command word for start
  output bcw_s ch_bcw, // block control word for start
  input wire logic [NUM_CH-1:0] ch_end, // per-channel transfer end pulse
  output logic irq, // unmasked completion flag pending
  input wire logic ch_mem_req, // channel wants a memory cycle
  input wire logic ch_mem_we, // channel write
  input wire logic [15:0] ch_mem_addr, // channel address
  input wire logic [31:0] ch_mem_wdata, // channel write data
  output logic ch_mem_gnt, // channel cycle taken this clock
  output logic mem_req, // memory cycle
  output logic mem_we, // memory write
  output logic [15:0] mem_addr, // memory word address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic [31:0] mem_rdata, // read data, cycle after request
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata // read data, cycle after strobe
);
  function automatic logic [MARK_W-1:0] mark_next(input logic [MARK_W-1:0] m);
    mark_next = (m == MARK_W'(CAT_DEPTH - 1)) ? '0 : m + MARK_W'(1);
  endfunction

  state_e state_q, state_d;
  logic [31:0] ir_q;
  logic [17:0] pc_q;
  logic [15:0] ea_q;
  cmd_word_s cmd_tmp_q;
  cat_entry_s high_tab_q [CAT_DEPTH];
  cat_entry_s low_tab_q [CAT_DEPTH];
  logic [MARK_W-1:0] high_load_marker_q, high_unload_marker_q;
  logic [MARK_W-1:0] low_load_marker_q, low_unload_marker_q;
  cmd_word_s cmd_reg_q [NUM_CH];
  bcw_s bcw_reg_q [NUM_CH];
  logic [NUM_CH-1:0] busy_q, flag_q, mask_q;
  logic [NUM_POS-1:0] scan_q;
  logic done_q;
  logic [17:0] npc_q;
  logic [7:0] e_q;
  logic [5:0] f_q;
  logic g_q;
  logic start_q, halt_q, drop_q;
  logic [3:0] sel_q;
  logic [2:0] drop_pos_q;
  logic [31:0] rdata_q;

  // Decode of the word presented at issue.
  wire [5:0] op = instr_word[`F_OP_HI:`F_OP_LO];
  wire [3:0] chan = instr_word[`F_CHAN_HI:`F_CHAN_LO];
  wire [2:0] pos = instr_word[`F_POS_HI:`F_POS_LO];
  wire [2:0] xf = instr_word[`F_X_HI:`F_X_LO];
  wire [15:0] wf = instr_word[`F_W_HI:`F_W_LO];
  wire ind = instr_word[`F_IND];
  wire use_x = (xf != `X_NONE) && (xf != `X_NO_MEANING);
  wire [15:0] ea_now = wf + (use_x ? xr_val : 16'h0000);
  wire take = instr_valid && (state_q == S_IDLE);
  wire is_test = take && (op == `OP_TEST_COND);
  wire is_hi_cyc = take && (op == `OP_HIGH_CYCLE);
  wire is_lo_cyc = take && (op == `OP_LOW_CYCLE);
  wire is_en = take && (op == `OP_SCAN_ENABLE);
  wire is_dis = take && (op == `OP_SCAN_DISABLE);
  wire is_init = take && (op == `OP_IO_INITIATE);
  wire is_save = take && (op == `OP_IO_SAVE);
  wire is_halt = take && (op == `OP_IO_HALT);
  wire is_other = take && !(is_test || is_hi_cyc || is_lo_cyc || is_en || is_dis
                  || is_init || is_save || is_halt);
  wire high_empty = (high_load_marker_q == high_unload_marker_q);
  wire low_empty = (low_load_marker_q == low_unload_marker_q);
  wire high_pop = is_hi_cyc && !high_empty;
  wire low_pop = is_lo_cyc && !low_empty;
  wire init_busy = is_init && busy_q[chan];
  wire [3:0] run_ch = ir_q[`F_CHAN_HI:`F_CHAN_LO];
  wire cond_match = (cond_val == instr_word[`F_UBIT]);

  // The table keeps one slot free so that equal markers can only mean empty.
  wire high_full = (mark_next(high_load_marker_q) == high_unload_marker_q);
  wire low_full = (mark_next(low_load_marker_q) == low_unload_marker_q);
  assign cat_wr_ready = cat_wr_high ? !high_full : !low_full;
  wire high_push = cat_wr_valid && cat_wr_high && !high_full;
  wire low_push = cat_wr_valid && !cat_wr_high && !low_full;

  // Channel memory traffic overlaps instruction execution and uses idle cycles.
  wire unit_mem = (state_q == S_IND_READ) || (state_q == S_CMD_READ)
                  || (state_q == S_BCW_READ) || (state_q == S_SAVE_CMD)
                  || (state_q == S_SAVE_BCW);
  assign ch_mem_gnt = ch_mem_req && !unit_mem;
  assign mem_req = unit_mem || ch_mem_req;
  assign mem_we = unit_mem ? ((state_q == S_SAVE_CMD) || (state_q == S_SAVE_BCW))
                  : ch_mem_we;
  assign mem_addr = (state_q == S_IND_READ) ? ir_q[`F_W_HI:`F_W_LO]
                  : ((state_q == S_BCW_READ) || (state_q == S_SAVE_BCW)) ? ea_q + 16'h0001
                  : unit_mem ? ea_q : ch_mem_addr;
  assign mem_wdata = (state_q == S_SAVE_CMD) ? cmd_reg_q[run_ch]
                   : (state_q == S_SAVE_BCW) ? bcw_reg_q[run_ch] : ch_mem_wdata;
  wire [15:0] ind_ea = mem_rdata[15:0] + ((xr_sel > `X_NO_MEANING) ? xr_val : 16'h0000);
  wire op_save = (ir_q[`F_OP_HI:`F_OP_LO] == `OP_IO_SAVE);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:
      begin
        if (high_pop || low_pop)
          state_d = S_CAT_LOAD;
        else if ((is_init && !init_busy) || is_save)
          state_d = ind ? S_IND_READ : (is_save ? S_SAVE_CMD : S_CMD_READ);
      end
      S_CAT_LOAD: state_d = S_IDLE;
      S_IND_READ: state_d = S_IND_TAKE;
      S_IND_TAKE: state_d = op_save ? S_SAVE_CMD : S_CMD_READ;
      S_CMD_READ: state_d = S_BCW_READ;
      S_BCW_READ: state_d = S_BCW_TAKE;
      S_BCW_TAKE: state_d = S_IDLE;
      S_SAVE_CMD: state_d = S_SAVE_BCW;
      S_SAVE_BCW: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  assign instr_ready = (state_q == S_IDLE);
  assign xr_sel = take ? xf : ir_q[`F_X_HI:`F_X_LO];
  assign cond_sel = ea_now;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      ir_q <= 32'h0000_0000;
      pc_q <= 18'h00000;
      ea_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      if (take)
      begin
        ir_q <= instr_word;
        pc_q <= instr_pc;
        ea_q <= ea_now;
      end
      else if (state_q == S_IND_TAKE)
        ea_q <= ind_ea;
    end
  end

  // Instruction completion and program counter choice.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      done_q <= 1'b0;
      npc_q <= 18'h00000;
    end
    else
    begin
      done_q <= 1'b0;
      if (is_test)
      begin
        done_q <= 1'b1;
        npc_q <= instr_pc + (cond_match ? `PC_STEP : `PC_SKIP);
      end
      else if ((is_hi_cyc && high_empty) || (is_lo_cyc && low_empty) || init_busy
               || is_en || is_dis || is_halt || is_other)
      begin
        done_q <= 1'b1;
        npc_q <= instr_pc + `PC_STEP;
      end
      else if (state_q == S_CAT_LOAD)
      begin
        done_q <= 1'b1;
        npc_q <= pc_q + `PC_SKIP;
      end
      else if (state_q == S_BCW_TAKE)
      begin
        done_q <= 1'b1;
        npc_q <= pc_q + `PC_SKIP;
      end
      else if (state_q == S_SAVE_BCW)
      begin
        done_q <= 1'b1;
        npc_q <= pc_q + `PC_STEP;
      end
    end
  end

  // Activity tables: the scanner loads, the cycle instructions unload.
  always_ff @(posedge clock)
  begin
    if (high_push)
      high_tab_q[high_load_marker_q] <= cat_wr_entry;
    if (low_push)
      low_tab_q[low_load_marker_q] <= cat_wr_entry;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      high_load_marker_q <= '0;
      high_unload_marker_q <= '0;
      low_load_marker_q <= '0;
      low_unload_marker_q <= '0;
      e_q <= 8'h00;
      f_q <= 6'h00;
      g_q <= 1'b0;
    end
    else
    begin
      if (high_push)
        high_load_marker_q <= mark_next(high_load_marker_q);
      if (low_push)
        low_load_marker_q <= mark_next(low_load_marker_q);
      if (high_pop)
      begin
        e_q <= high_tab_q[high_unload_marker_q].character;
        f_q <= high_tab_q[high_unload_marker_q].ident;
        g_q <= high_tab_q[high_unload_marker_q].io_dir;
        high_unload_marker_q <= mark_next(high_unload_marker_q);
      end
      else if (low_pop)
      begin
        e_q <= low_tab_q[low_unload_marker_q].character;
        f_q <= low_tab_q[low_unload_marker_q].ident;
        g_q <= low_tab_q[low_unload_marker_q].io_dir;
        low_unload_marker_q <= mark_next(low_unload_marker_q);
      end
    end
  end

  // Scanner positions.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scan_q <= '0;
      drop_q <= 1'b0;
      drop_pos_q <= 3'h0;
    end
    else
    begin
      drop_q <= is_dis;
      if (is_dis)
        drop_pos_q <= pos;
      if (is_en)
        scan_q[pos] <= 1'b1;
      else if (is_dis)
        scan_q[pos] <= 1'b0;
    end
  end

  // Channel registers, busy state and completion flags.
  always_ff @(posedge clock)
  begin
    if (state_q == S_BCW_READ)
      cmd_tmp_q <= mem_rdata;
    if (state_q == S_BCW_TAKE)
    begin
      cmd_reg_q[run_ch] <= cmd_tmp_q;
      bcw_reg_q[run_ch] <= mem_rdata;
    end
    else if (is_halt)
    begin
      // Contents are not guaranteed after a halt; clearing costs nothing.
      cmd_reg_q[chan] <= '0;
      bcw_reg_q[chan] <= '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busy_q <= '0;
      flag_q <= '0;
      mask_q <= '0;
      start_q <= 1'b0;
      halt_q <= 1'b0;
      sel_q <= 4'h0;
    end
    else
    begin
      start_q <= (state_q == S_BCW_TAKE);
      halt_q <= is_halt;
      if (state_q == S_BCW_TAKE)
        sel_q <= run_ch;
      else if (is_halt)
        sel_q <= chan;
      // A new end pulse wins over a software clear in the same cycle.
      flag_q <= (flag_q & ~((reg_wr && reg_addr == `REG_DONE)
                ? reg_wdata[NUM_CH-1:0] : '0)) | ch_end;
      if (reg_wr && reg_addr == `REG_MASK)
        mask_q <= reg_wdata[NUM_CH-1:0];
      busy_q <= (busy_q & ~ch_end & ~(is_halt ? (NUM_CH'(1) << chan) : '0))
                | ((state_q == S_BCW_TAKE) ? (NUM_CH'(1) << run_ch) : '0);
    end
  end

  assign ch_cmd = cmd_reg_q[sel_q];
  assign ch_bcw = bcw_reg_q[sel_q];

  // Register read port.
  wire [31:0] rd_mux = (reg_addr == `REG_MASK) ? 32'(mask_q)
                     : (reg_addr == `REG_DONE) ? 32'(flag_q)
                     : (reg_addr == `REG_BUSY) ? 32'(busy_q)
                     : (reg_addr == `REG_SCAN) ? 32'(scan_q)
                     : (reg_addr == `REG_MARKERS) ? {16'h0000,
                        8'(high_load_marker_q), 8'(high_unload_marker_q)} ^ 32'h0000_0000
                     : 32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  assign done = done_q;
  assign next_pc = npc_q;
  assign reg_e = e_q;
  assign reg_f = f_q;
  assign reg_g = g_q;
  assign scan_en = scan_q;
  assign scan_drop = drop_q;
  assign scan_drop_pos = drop_pos_q;
  assign ch_start = start_q;
  assign ch_halt = halt_q;
  assign ch_sel = sel_q;
  assign irq = |(flag_q & mask_q);
  assign reg_rdata = rdata_q;
endmodule

// ==== io_unit_sva.sv ====
// Port-level assertions for the I/O instruction unit.
`timescale 1ns/1ps
`include "io_instruction_unit_consts.svh"
module io_unit_sva #(
  parameter int NUM_POS = 8 // scanner positions
)(
  input wire logic clock, // clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic instr_valid, // instruction issue
  input wire logic [31:0] instr_word, // instruction word
  input wire logic [17:0] instr_pc, // instruction address
  input wire logic instr_ready, // unit idle
  input wire logic done, // instruction finished
  input wire logic [17:0] next_pc, // next address
  input wire logic cond_val, // addressed condition state
  input wire logic [NUM_POS-1:0] scan_en, // positions in operation
  input wire logic scan_drop, // partial character dropped
  input wire logic [2:0] scan_drop_pos, // position disabled
  input wire logic ch_start, // channel start pulse
  input wire logic ch_halt, // channel halt pulse
  input wire logic ch_mem_req, // channel memory request
  input wire logic ch_mem_we, // channel write
  input wire logic [15:0] ch_mem_addr, // channel address
  input wire logic ch_mem_gnt, // channel cycle taken
  input wire logic mem_req, // memory cycle
  input wire logic mem_we, // memory write
  input wire logic [15:0] mem_addr // memory address
);
  logic take;
  logic [5:0] op;
  logic [2:0] pos_q;
  assign take = instr_valid && instr_ready;
  assign op = instr_word[31:26];
  always_ff @(posedge clock)
    pos_q <= instr_word[24:22];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_one_step;
    done && next_pc == $past(instr_pc) + 18'h1;
  endsequence
  sequence s_pop_go;
    !done ##1 done && next_pc == $past(instr_pc, 2) + 18'h2;
  endsequence
  sequence s_init_go;
    mem_req && !mem_we ##1 mem_req && !mem_we && mem_addr == $past(mem_addr) + 16'h1
      ##1 !done ##1 done && ch_start && next_pc == $past(instr_pc, 4) + 18'h2;
  endsequence
  sequence s_save;
    mem_req && mem_we ##1 mem_req && mem_we && mem_addr == $past(mem_addr) + 16'h1
      ##1 done && next_pc == $past(instr_pc, 3) + 18'h1;
  endsequence
  property p_test_eq;
    take && op == `OP_TEST_COND && instr_word[25] == cond_val |=> s_one_step;
  endproperty
  a_test_eq: assert property (p_test_eq) else $error("condition match did not step");
  property p_test_ne;
    take && op == `OP_TEST_COND && instr_word[25] != cond_val
      |=> done && next_pc == $past(instr_pc) + 18'h2;
  endproperty
  a_test_ne: assert property (p_test_ne) else $error("condition mismatch did not skip");
  property p_pop;
    take && (op == `OP_HIGH_CYCLE || op == `OP_LOW_CYCLE) |=> s_one_step or s_pop_go;
  endproperty
  a_pop: assert property (p_pop) else $error("character cycle timing wrong");
  property p_scan_on;
    take && op == `OP_SCAN_ENABLE |=> done && scan_en[pos_q];
  endproperty
  a_scan_on: assert property (p_scan_on) else $error("position not enabled");
  property p_scan_off;
    take && op == `OP_SCAN_DISABLE
      |=> done && scan_drop && scan_drop_pos == pos_q && !scan_en[pos_q];
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("position not disabled");
  property p_init;
    take && op == `OP_IO_INITIATE && !instr_word[21] |=> (s_one_step and !ch_start) or s_init_go;
  endproperty
  a_init: assert property (p_init) else $error("initiate sequence wrong");
  property p_save;
    take && op == `OP_IO_SAVE && !instr_word[21] |=> s_save;
  endproperty
  a_save: assert property (p_save) else $error("save sequence wrong");
  property p_halt;
    take && op == `OP_IO_HALT |=> s_one_step ##[0:1] ch_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop channel");
  property p_gnt;
    ch_mem_gnt |-> ch_mem_req && mem_req && mem_addr == ch_mem_addr && mem_we == ch_mem_we;
  endproperty
  a_gnt: assert property (p_gnt) else $error("channel cycle not on memory");
endmodule

// ==== chan_side_model.sv ====
// Far-side model: core memory, channel memory traffic and transfer ends.
`timescale 1ns/1ps
module chan_side_model (
  input wire logic clock, // clock
  input wire logic rst_n, // reset, active low
  input wire logic mem_req, // memory cycle
  input wire logic mem_we, // memory write
  input wire logic [15:0] mem_addr, // word address
  input wire logic [31:0] mem_wdata, // write data
  output logic [31:0] mem_rdata, // read data, cycle after request
  output logic ch_mem_req, // channel memory request
  output logic ch_mem_we, // channel write
  output logic [15:0] ch_mem_addr, // channel address
  output logic [31:0] ch_mem_wdata, // channel write data
  input wire logic ch_mem_gnt, // channel cycle taken
  input wire logic [15:0] end_cmd, // bench asks for transfer ends
  output logic [15:0] ch_end // transfer end pulses
);
  logic [31:0] mem [256];
  always @(posedge clock)
  begin
    if (mem_req && mem_we && !mem_addr[15])
      mem[mem_addr[7:0]] <= mem_wdata;
    // Outside a read the bus flips, so stale data can never pass for an answer.
    mem_rdata <= !rst_n ? 32'h0 : (mem_req && !mem_we) ? mem[mem_addr[7:0]] : ~mem_rdata;
    ch_end <= rst_n ? end_cmd : 16'h0000;
    // Channel traffic stays in the upper half, away from program words, and waits for a grant.
    if (!rst_n || !ch_mem_req || ch_mem_gnt)
    begin
      ch_mem_req <= rst_n && ($urandom % 3) == 0;
      ch_mem_we <= 1'($urandom);
      ch_mem_addr <= {1'b1, 15'($urandom)};
      ch_mem_wdata <= $urandom;
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the I/O instruction unit.
`timescale 1ns/1ps
`include "io_instruction_unit_consts.svh"
module tb_top
  import io_instruction_unit_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, cond_val = 1'b0;
  logic cat_wr_valid = 1'b0, cat_wr_high = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cv;
  logic [31:0] instr_word = '0, reg_wdata = '0, cw, bw;
  logic [17:0] instr_pc = '0, next_pc;
  logic [15:0] xr_val = '0, end_cmd = '0, xv, cond_sel, ch_mem_addr, mem_addr, ch_end;
  logic [7:0] reg_addr = '0, reg_e, scan_en;
  cat_entry_s cat_wr_entry = '0;
  logic instr_ready, done, cat_wr_ready, scan_drop, ch_start, ch_halt, irq, reg_g;
  logic ch_mem_req, ch_mem_we, ch_mem_gnt, mem_req, mem_we;
  logic [5:0] reg_f;
  logic [3:0] ch_sel;
  logic [2:0] xr_sel, scan_drop_pos;
  cmd_word_s ch_cmd;
  bcw_s ch_bcw;
  logic [31:0] ch_mem_wdata, mem_wdata, mem_rdata, reg_rdata;
  int err_total = 0, n_tests = 0, i, j, r;
  logic [17:0] exp_q[$];
  cat_entry_s hq[$], lq[$];
  // A small table keeps the fill, refusal and wrap cases short.
  io_instruction_unit #(.CAT_DEPTH(4), .MARK_W(2)) io_instruction_unit_inst (.*);
  chan_side_model chan_side_model_inst (.*);
  always #25 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clock)
    if (done === 1'b1)
      check(next_pc, exp_q.size() ? exp_q.pop_front() : 18'hx);
  task automatic issue(input logic [5:0] op, input logic [3:0] f, input logic ind,
      input logic [2:0] x, input logic [15:0] w, input logic [17:0] d);
    logic [17:0] p;
    int k;
    p = 18'($urandom);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= {op, f, ind, x, w, 2'b00};
    instr_pc <= p;
    cond_val <= cv;
    xr_val <= xv;
    exp_q.push_back(p + d);
    @(negedge clock);
    check(cond_sel, 16'(w + ((x > 3'h1) ? xv : 16'h0000)));
    check(xr_sel, x);
    @(posedge clock);
    instr_valid <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++)
      @(negedge clock);
  endtask
  task automatic push(input logic hi, input logic room);
    cat_entry_s e;
    e = cat_entry_s'($urandom);
    @(posedge clock);
    cat_wr_valid <= 1'b1;
    cat_wr_high <= hi;
    cat_wr_entry <= e;
    @(negedge clock);
    check(cat_wr_ready, room);
    if (room && hi)
      hq.push_back(e);
    else if (room)
      lq.push_back(e);
    @(posedge clock);
    cat_wr_valid <= 1'b0;
  endtask
  task automatic pop(input logic hi);
    cat_entry_s e;
    logic [5:0] op;
    op = hi ? `OP_HIGH_CYCLE : `OP_LOW_CYCLE;
    if ((hi ? hq.size() : lq.size()) == 0)
      issue(op, 4'h0, 1'b0, 3'h0, 16'h0, 18'h1);
    else
    begin
      e = hi ? hq.pop_front() : lq.pop_front();
      issue(op, 4'h0, 1'b0, 3'h0, 16'h0, 18'h2);
      check({reg_e, reg_f, reg_g}, e);
    end
  endtask
  task automatic reg_cycle(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clock);
    if (!wr)
      check(reg_rdata, v);
  endtask
  task automatic chan_init(input logic [2:0] x, input logic [17:0] d);
    issue(`OP_IO_INITIATE, 4'h5, 1'b0, x, 16'h0010, d);
    if (d == 18'h2)
    begin
      check(ch_sel, 32'h5);
      check(ch_cmd, cw);
      check(ch_bcw, bw);
    end
  endtask
  initial
  begin
    void'($urandom(91819));
    cv = 1'b0;
    xv = 16'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      cv = i[0];
      issue(`OP_TEST_COND, {i[1], 3'h0}, 1'b0, 3'h0, 16'(i), (i[1] == i[0]) ? 18'h1 : 18'h2);
    end
    for (i = 0; i < 8; i++)
    begin
      issue(`OP_SCAN_ENABLE, 4'(i), 1'b0, 3'h0, 16'h0, 18'h1);
      check(scan_en[i], 1'b1);
    end
    issue(`OP_SCAN_DISABLE, 4'h3, 1'b0, 3'h0, 16'h0, 18'h1);
    check(scan_en, 8'hf7);
    for (r = 0; r < 2; r++)
    begin
      for (j = 0; j < 4; j++)
      begin
        push(1'b1, j < 3);
        push(1'b0, j < 3);
      end
      for (j = 0; j < 4; j++)
        pop(1'b1);
      for (j = 0; j < 4; j++)
        pop(1'b0);
    end
    cw = $urandom;
    bw = $urandom;
    chan_side_model_inst.mem[8'h10] = cw;
    chan_side_model_inst.mem[8'h11] = bw;
    chan_side_model_inst.mem[8'h20] = cw;
    chan_side_model_inst.mem[8'h21] = bw;
    chan_side_model_inst.mem[8'h30] = 32'h0000_0040;
    chan_side_model_inst.mem[8'h40] = ~cw;
    chan_side_model_inst.mem[8'h41] = ~bw;
    xv = 16'h0010;
    chan_init(3'h2, 18'h2);
    chan_init(3'h1, 18'h1);
    xv = 16'h0000;
    issue(`OP_IO_INITIATE, 4'h6, 1'b1, 3'h0, 16'h0030, 18'h2);
    check(ch_cmd, ~cw);
    issue(`OP_IO_SAVE, 4'h5, 1'b0, 3'h0, 16'h0050, 18'h1);
    check(chan_side_model_inst.mem[8'h50], cw);
    check(chan_side_model_inst.mem[8'h51], bw);
    issue(`OP_IO_SAVE, 4'h9, 1'b0, 3'h0, 16'h0060, 18'h1);
    reg_cycle(1'b1, `REG_MASK, 32'h0);
    @(posedge clock);
    end_cmd <= 16'h0020;
    @(posedge clock);
    end_cmd <= 16'h0000;
    repeat (2) @(negedge clock);
    check(irq, 1'b0);
    reg_cycle(1'b0, `REG_DONE, 32'h20);
    reg_cycle(1'b1, `REG_MASK, 32'h20);
    check(irq, 1'b1);
    reg_cycle(1'b1, `REG_DONE, 32'h20);
    check(irq, 1'b0);
    reg_cycle(1'b0, 8'hfc, 32'h0);
    reg_cycle(1'b0, `REG_MASK, 32'h20);
    xv = 16'h0055;
    chan_init(3'h1, 18'h2);
    issue(`OP_IO_HALT, 4'h5, 1'b0, 3'h0, 16'h0, 18'h1);
    issue(`OP_IO_HALT, 4'hc, 1'b0, 3'h0, 16'h0, 18'h1);
    chan_init(3'h0, 18'h2);
    repeat (4) @(posedge clock);
    check(32'(exp_q.size()), 32'h0);
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("Error at %0t: run did not finish", $time);
    test_done;
  end
endmodule
bind io_instruction_unit io_unit_sva #(.NUM_POS(NUM_POS)) io_unit_sva_inst (.*);
